// *** hdl/serial_spi_uart_unit.sv ***
/*
  Serial unit: SPI master or slave with all four clock modes, 4-pin enable
  handling and a UART transmitter sharing the transmit flags.
  Assumes one 50 MHz clock; pins come from outside and are synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_spi_uart_unit #(
  parameter int DIV_W = serial_unit_pkg::DIV_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Configuration
  input wire logic software_reset_hold_in,
  input wire logic master_mode_in,
  input wire logic uart_mode_in,
  input wire logic four_pin_mode_in,
  input wire logic enable_pin_direction_in,
  input wire logic capture_phase_select_in,
  input wire logic clock_idle_polarity_in,
  input wire logic [DIV_W-1:0] bit_divider_in,
  // Software data access
  input wire logic tx_write_in,
  input wire logic [7:0] tx_data_in,
  input wire logic rx_read_in,
  input wire logic tx_complete_clear_in,
  output logic [7:0] rx_holding_buffer_out,
  // Status
  output logic tx_buffer_empty_flag_out,
  output logic rx_char_ready_flag_out,
  output logic transfer_active_flag_out,
  output logic tx_complete_flag_out,
  output logic clock_request_out,
  // SPI pins
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe_out,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_out,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_out,
  input wire logic slave_enable_pin_in,
  output logic slave_enable_pin_out,
  output logic slave_enable_pin_oe_out,
  // UART pin
  output logic uart_txd_out
);
  // ==========================================================
  // Pin synchronisation
  pin_sync_if #(.W(serial_unit_pkg::PIN_COUNT)) pins ();
  assign pins.raw = {slave_enable_pin_in, miso_in, mosi_in, sclk_in};

  pin_sync #(.W(serial_unit_pkg::PIN_COUNT)) u_sync (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .pins(pins)
  );

  // ==========================================================
  // State
  serial_unit_pkg::engine_state_e state;
  logic unit_rst;
  logic [DIV_W-1:0] div_cnt;
  logic tick;
  logic active;
  logic [serial_unit_pkg::CNT_W-1:0] bit_cnt;
  logic [serial_unit_pkg::CNT_W-1:0] samp_cnt;
  logic [7:0] tx_hold;
  logic tx_full;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  logic armed;
  logic loaded;
  logic rx_ready;
  logic tx_cpt;
  logic txd;

  // Software reset holds everything except the pin synchroniser in its reset state
  assign unit_rst = !resetn_in || software_reset_hold_in;

  // ==========================================================
  // Mode decode
  logic spi_mode;
  logic ste_low;
  logic master_blocked;
  logic slave_selected;
  logic slave_live;
  logic start_spi;
  logic start_uart;
  logic abort;

  assign spi_mode = !uart_mode_in;
  assign ste_low = !pins.level[serial_unit_pkg::PIN_STE];
  // Another master owns the bus while the enable input is low
  assign master_blocked = four_pin_mode_in && !enable_pin_direction_in && ste_low;
  assign slave_selected = !four_pin_mode_in || ste_low;
  // Slave only listens once the clock has been seen at idle
  assign slave_live = spi_mode && !master_mode_in && armed && slave_selected;
  assign start_uart = (state == serial_unit_pkg::ST_IDLE) && uart_mode_in && tx_full;
  assign start_spi = (state == serial_unit_pkg::ST_IDLE) && spi_mode && master_mode_in
                     && tx_full && !master_blocked;
  // Enable going low mid-transfer drops the character
  assign abort = (state == serial_unit_pkg::ST_SPI_RUN) && master_blocked;

  // ==========================================================
  // Bit-rate divider, restarted with each transfer
  // Restarting keeps the first clock phase at full length
  always_ff @(posedge clk_in)
  begin
    if (unit_rst || start_spi || start_uart || state == serial_unit_pkg::ST_IDLE)
      div_cnt <= '0;
    else if (tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 1'b1;
  end

  assign tick = (state != serial_unit_pkg::ST_IDLE) && (div_cnt == bit_divider_in);

  // ==========================================================
  // Clock edge events, shared by master and slave
  logic m_lead;
  logic m_trail;
  logic s_lead;
  logic s_trail;
  logic lead;
  logic trail;
  logic sample_ev;
  logic shift_do;
  logic char_done;
  logic m_end;
  logic [7:0] rx_next;

  assign m_lead = (state == serial_unit_pkg::ST_SPI_RUN) && tick && !active;
  assign m_trail = (state == serial_unit_pkg::ST_SPI_RUN) && tick && active;
  assign s_lead = slave_live && (clock_idle_polarity_in ? pins.fall[serial_unit_pkg::PIN_SCLK]
                                                        : pins.rise[serial_unit_pkg::PIN_SCLK]);
  assign s_trail = slave_live && (clock_idle_polarity_in ? pins.rise[serial_unit_pkg::PIN_SCLK]
                                                         : pins.fall[serial_unit_pkg::PIN_SCLK]);
  assign lead = m_lead || s_lead;
  assign trail = m_trail || s_trail;
  // Phase picks which edge samples and which shifts
  assign sample_ev = capture_phase_select_in ? trail : lead;
  // No shift before the first sample or after the last one
  assign shift_do = (capture_phase_select_in ? lead : trail) && (samp_cnt != '0);
  assign char_done = sample_ev && (samp_cnt == serial_unit_pkg::LAST_CHAR_BIT);
  assign m_end = m_trail && (bit_cnt == serial_unit_pkg::LAST_CHAR_BIT);
  assign rx_next = {rx_sh[6:0], master_mode_in ? pins.level[serial_unit_pkg::PIN_MISO]
                                               : pins.level[serial_unit_pkg::PIN_MOSI]};

  // ==========================================================
  // Engine state machine
  always_ff @(posedge clk_in)
  begin
    if (unit_rst)
      state <= serial_unit_pkg::ST_IDLE;
    else
    begin
      unique case (state)
        serial_unit_pkg::ST_IDLE:
          if (start_uart)
            state <= serial_unit_pkg::ST_UART_RUN;
          else if (start_spi)
            state <= serial_unit_pkg::ST_SPI_RUN;
        serial_unit_pkg::ST_SPI_RUN:
          if (abort || m_end)
            state <= serial_unit_pkg::ST_IDLE;
        serial_unit_pkg::ST_UART_RUN:
          if (tick && bit_cnt == serial_unit_pkg::UART_STOP_BIT)
            state <= serial_unit_pkg::ST_IDLE;
      endcase
    end
  end

  // Master clock level and clock/bit counter
  always_ff @(posedge clk_in)
  begin
    if (unit_rst || state == serial_unit_pkg::ST_IDLE)
    begin
      active <= 1'b0;
      bit_cnt <= '0;
    end
    else if (tick)
    begin
      if (state == serial_unit_pkg::ST_SPI_RUN)
        active <= !active;
      if (state == serial_unit_pkg::ST_UART_RUN || active)
        bit_cnt <= bit_cnt + 1'b1;
    end
  end

  // Slave waits for the clock at its idle level after release
  always_ff @(posedge clk_in)
  begin
    if (unit_rst || master_mode_in)
      armed <= 1'b0;
    else if (pins.level[serial_unit_pkg::PIN_SCLK] == clock_idle_polarity_in)
      armed <= 1'b1;
  end

  // ==========================================================
  // Transmit holding buffer and shifter
  logic slave_load;
  // A write before the first sample replaces the zero fill, so the first character goes out intact
  assign slave_load = slave_live && (!loaded || (tx_full && samp_cnt == '0));

  always_ff @(posedge clk_in)
  begin
    if (unit_rst)
    begin
      tx_hold <= serial_unit_pkg::DATA_RESET;
      tx_full <= 1'b0;
    end
    else if (tx_write_in)
    begin
      tx_hold <= tx_data_in;
      tx_full <= 1'b1; // Write wins over a same-cycle load
    end
    else if (start_spi || start_uart || (slave_load && tx_full))
      tx_full <= 1'b0;
  end

  // Slave sends zeros when nothing was written
  always_ff @(posedge clk_in)
  begin
    if (unit_rst)
      tx_sh <= serial_unit_pkg::DATA_RESET;
    else if (start_spi || start_uart)
      tx_sh <= tx_hold;
    else if (slave_load)
      tx_sh <= tx_full ? tx_hold : serial_unit_pkg::DATA_RESET;
    else if (shift_do)
      tx_sh <= {tx_sh[6:0], 1'b0};
  end

  // Slave character framing, cleared when deselected
  always_ff @(posedge clk_in)
  begin
    if (unit_rst || !slave_live)
      loaded <= 1'b0;
    else if (char_done)
      loaded <= 1'b0;
    else if (slave_load)
      loaded <= 1'b1;
  end

  // ==========================================================
  // Receive path
  always_ff @(posedge clk_in)
  begin
    if (unit_rst || start_spi || abort || (!master_mode_in && !slave_live))
    begin
      samp_cnt <= '0;
      rx_sh <= serial_unit_pkg::DATA_RESET;
    end
    else if (sample_ev)
    begin
      rx_sh <= rx_next;
      samp_cnt <= char_done ? '0 : samp_cnt + 1'b1;
    end
  end

  // Completed character lands in the holding buffer
  always_ff @(posedge clk_in)
  begin
    if (unit_rst)
      rx_holding_buffer_out <= serial_unit_pkg::DATA_RESET;
    else if (char_done)
      rx_holding_buffer_out <= rx_next;
  end

  // Set wins over a read in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (unit_rst)
      rx_ready <= 1'b0;
    else if (char_done)
      rx_ready <= 1'b1;
    else if (rx_read_in)
      rx_ready <= 1'b0;
  end

  // ==========================================================
  // UART transmitter: start, eight data bits LSB first, stop
  always_ff @(posedge clk_in)
  begin
    if (unit_rst)
      txd <= serial_unit_pkg::IDLE_LINE;
    else if (start_uart)
      txd <= 1'b0;
    else if (state == serial_unit_pkg::ST_UART_RUN && tick)
    begin
      if (bit_cnt < serial_unit_pkg::LAST_CHAR_BIT + 1'b1)
        txd <= tx_sh[bit_cnt[2:0]];
      else
        txd <= serial_unit_pkg::IDLE_LINE;
    end
  end

  // Complete flag rises after every UART byte, buffer empty or not; SPI bytes never set it
  always_ff @(posedge clk_in)
  begin
    if (unit_rst)
      tx_cpt <= 1'b0;
    else if (state == serial_unit_pkg::ST_UART_RUN && tick && bit_cnt == serial_unit_pkg::UART_STOP_BIT)
      tx_cpt <= 1'b1;
    else if (tx_complete_clear_in)
      tx_cpt <= 1'b0;
  end

  // ==========================================================
  // Outputs
  logic busy;
  assign busy = (state != serial_unit_pkg::ST_IDLE) || (slave_live && samp_cnt != '0);
  assign transfer_active_flag_out = busy;
  assign clock_request_out = busy;
  assign tx_buffer_empty_flag_out = !tx_full;
  assign rx_char_ready_flag_out = rx_ready;
  assign tx_complete_flag_out = tx_cpt;
  assign uart_txd_out = txd;

  // Clock rests at the polarity level whenever not active
  assign sclk_out = clock_idle_polarity_in ^ active;
  assign sclk_oe_out = !unit_rst && spi_mode && master_mode_in;
  assign mosi_out = tx_sh[7];
  assign mosi_oe_out = !unit_rst && spi_mode && master_mode_in;
  assign miso_out = tx_sh[7];
  assign miso_oe_out = slave_live;
  // Enable output is low for the length of a master transfer
  assign slave_enable_pin_out = (state != serial_unit_pkg::ST_SPI_RUN);
  assign slave_enable_pin_oe_out = !unit_rst && spi_mode && master_mode_in
                                   && four_pin_mode_in && enable_pin_direction_in;
endmodule : serial_spi_uart_unit
`default_nettype wire

// *** hdl/serial_unit_pkg.sv ***
/*
  Shared constants and types for the serial SPI/UART unit.
  Assumes a single 50 MHz clock domain; all pins are synchronised before use.
*/
package serial_unit_pkg;
  // Character and frame layout
  localparam int CHAR_BITS = 8;
  localparam int UART_FRAME_BITS = 10;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] LAST_CHAR_BIT = 4'h7;
  localparam logic [CNT_W-1:0] UART_STOP_BIT = 4'h9;
  // Default bit-rate divider width
  localparam int DIV_W = 16;
  // Synchronised pin positions
  localparam int PIN_COUNT = 4;
  localparam int PIN_SCLK = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_STE = 3;
  // Reset values
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic IDLE_LINE = 1'b1;
  // Engine states
  typedef enum logic [1:0] {ST_IDLE, ST_SPI_RUN, ST_UART_RUN} engine_state_e;
endpackage : serial_unit_pkg

// *** hdl/pin_sync_if.sv ***
/*
  Carrier between the serial unit and its pin synchroniser.
  Assumes raw pins are driven by the user side and all other signals by the synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport sync (input raw, output level, output rise, output fall);
  modport user (output raw, input level, input rise, input fall);
endinterface : pin_sync_if
`default_nettype wire

// *** hdl/pin_sync.sv ***
/*
  Two-flip-flop synchroniser with edge detection for a group of pins.
  Assumes the pins are asynchronous to clk_in; only the second and third stages are observed.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Pin group
  pin_sync_if.sync pins
);
  // ==========================================================
  // Synchroniser stages
  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] prev;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      meta <= '0;
      stable <= '0;
      prev <= '0;
    end
    else
    begin
      meta <= pins.raw;
      stable <= meta;
      prev <= stable;
    end
  end

  // Edges come from the settled stages only
  assign pins.level = stable;
  assign pins.rise = stable & ~prev;
  assign pins.fall = ~stable & prev;
endmodule : pin_sync
`default_nettype wire

// *** dv/serial_spi_uart_unit_chk.sv ***
/*
  Port-level checks for the serial unit.
  Assumes it is bound into every serial unit instance.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_spi_uart_unit_chk #(
  parameter int DIV_W = serial_unit_pkg::DIV_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Configuration and software side
  input wire logic software_reset_hold_in,
  input wire logic master_mode_in,
  input wire logic uart_mode_in,
  input wire logic four_pin_mode_in,
  input wire logic enable_pin_direction_in,
  input wire logic clock_idle_polarity_in,
  input wire logic [DIV_W-1:0] bit_divider_in,
  input wire logic tx_write_in,
  // Status and pins
  input wire logic tx_buffer_empty_flag_out,
  input wire logic rx_char_ready_flag_out,
  input wire logic transfer_active_flag_out,
  input wire logic tx_complete_flag_out,
  input wire logic clock_request_out,
  input wire logic sclk_out,
  input wire logic sclk_oe_out,
  input wire logic slave_enable_pin_in,
  input wire logic slave_enable_pin_out,
  input wire logic slave_enable_pin_oe_out
);
  // ==========
  // Helpers
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [DIV_W:0] stable_cnt;
  logic sclk_prev;
  wire logic spi_master = master_mode_in && !uart_mode_in;
  wire logic guarded = four_pin_mode_in && !enable_pin_direction_in;
  // Cycles the master clock has held still; a stretched phase shows as a big count
  always_ff @(posedge clk_in)
  begin
    sclk_prev <= sclk_out;
    if (!transfer_active_flag_out || sclk_out != sclk_prev)
      stable_cnt <= '0;
    else
      stable_cnt <= stable_cnt + 1'b1;
  end
  // Idle master held off by a low enable input for longer than the synchroniser
  sequence blocked_s;
    (spi_master && guarded && !slave_enable_pin_in && !transfer_active_flag_out) [*6];
  endsequence
  // ==========
  // Assertions
  AST_IDLE_LEVEL: assert property (sclk_oe_out && !guarded && !transfer_active_flag_out
    |-> sclk_out == clock_idle_polarity_in) else $error("clock off idle level");
  AST_HOLD_CLEARS: assert property (software_reset_hold_in |-> !sclk_oe_out
    ##1 (tx_buffer_empty_flag_out && !rx_char_ready_flag_out && !transfer_active_flag_out && !tx_complete_flag_out))
    else $error("hold did not reset unit");
  AST_CLOCK_REQUEST: assert property (clock_request_out == transfer_active_flag_out)
    else $error("clock request differs from busy");
  AST_DONE_FLAGS: assert property ($fell(transfer_active_flag_out) && spi_master && !guarded
    && !$past(software_reset_hold_in) |-> ##[0:2] rx_char_ready_flag_out) else $error("busy ended without char");
  AST_WRITE_FILLS: assert property (tx_write_in && !software_reset_hold_in |=> !tx_buffer_empty_flag_out)
    else $error("write left buffer empty");
  AST_ENABLE_OUT: assert property (spi_master && four_pin_mode_in && enable_pin_direction_in
    && transfer_active_flag_out && $past(transfer_active_flag_out) |-> slave_enable_pin_oe_out
    && !slave_enable_pin_out) else $error("enable pin not driven active");
  AST_ENABLE_BLOCKS: assert property (blocked_s |=> !transfer_active_flag_out)
    else $error("master started while blocked");
  AST_PHASE_LENGTH: assert property (spi_master && sclk_oe_out
    |-> stable_cnt <= {1'b0, bit_divider_in} + 1'b1) else $error("clock phase stretched");
  // Main scenarios
  COV_SLAVE_RX: cover property (!master_mode_in && $rose(rx_char_ready_flag_out));
  COV_UART_DONE: cover property (uart_mode_in && $rose(tx_complete_flag_out));
  COV_BLOCKED: cover property (blocked_s);
endmodule : serial_spi_uart_unit_chk
bind serial_spi_uart_unit serial_spi_uart_unit_chk #(.DIV_W(DIV_W)) u_chk (.*);
`default_nettype wire

// *** dv/spi_peer_model.sv ***
/*
  Far side of the SPI pins: a master clocking one character per call,
  and an echo slave returning mosi on miso.
  Assumes the bench resolves shared lines and calls tasks from one process.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
  // Resolved lines
  input wire logic mosi_line,
  input wire logic miso_line,
  // Far-side drivers
  output logic peer_sclk,
  output logic peer_mosi,
  output logic peer_sel_n,
  output logic peer_miso
);
  // Echo slave, so a master sees its own character come back
  assign peer_miso = mosi_line;
  // Deselected, clock parked low
  initial
  begin
    peer_sclk = 1'b0;
    peer_mosi = 1'b0;
    peer_sel_n = 1'b1;
  end
  // Clock stands still at idle level outside frames
  task idle(input logic cpol);
    peer_sclk = cpol;
  endtask : idle
  // One character as master, MSB first, 160 ns clock period
  task xfer(input logic cpha, input logic cpol, input logic [7:0] tx, output logic [7:0] rx);
    #7 peer_sel_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      if (!cpha) peer_mosi = tx[i];
      #80 peer_sclk = !cpol;
      if (cpha) peer_mosi = tx[i]; else rx[i] = miso_line;
      #80 peer_sclk = cpol;
      if (cpha) rx[i] = miso_line;
    end
    #80 peer_sel_n = 1'b1;
    peer_mosi = !peer_mosi; // Released line must not keep the last bit
  endtask : xfer
endmodule : spi_peer_model
`default_nettype wire

// *** dv/serial_spi_uart_unit_test.sv ***
/*
  Bench for the serial unit: table of SPI characters in all clock modes,
  then reset, enable-pin and UART cases.
  Assumes the peer model and checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_spi_uart_unit_test;
  typedef struct packed {logic m; logic ph; logic pl; logic [7:0] tx; logic [7:0] px;} row_s;
  // Dummy 0x00 closes the master rows and releases the clock request
  localparam row_s ROWS [8] = '{'{1, 0, 0, 8'h81, 0}, '{1, 0, 1, 8'h3c, 0}, '{1, 1, 0, 8'h5a, 0},
    '{1, 1, 1, 8'h00, 0}, '{0, 0, 0, 8'hc3, 8'h96}, '{0, 0, 1, 8'h01, 8'h80},
    '{0, 1, 0, 8'h7e, 8'he1}, '{0, 1, 1, 8'hb4, 8'h2d}};
  logic clk_in = 1'b0;
  logic resetn_in, software_reset_hold_in, master_mode_in, uart_mode_in, four_pin_mode_in;
  logic enable_pin_direction_in, capture_phase_select_in, clock_idle_polarity_in;
  logic tx_write_in, rx_read_in, tx_complete_clear_in;
  logic [15:0] bit_divider_in;
  logic [7:0] tx_data_in, rx_holding_buffer_out;
  logic tx_buffer_empty_flag_out, rx_char_ready_flag_out, transfer_active_flag_out, tx_complete_flag_out;
  logic clock_request_out, sclk_out, sclk_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out;
  logic slave_enable_pin_out, slave_enable_pin_oe_out, uart_txd_out;
  logic peer_sclk, peer_mosi, peer_sel_n, peer_miso;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  // Shared lines: whoever enables drives, else the far side
  wire logic sclk_in = sclk_oe_out ? sclk_out : peer_sclk;
  wire logic mosi_in = mosi_oe_out ? mosi_out : peer_mosi;
  wire logic miso_in = miso_oe_out ? miso_out : peer_miso;
  wire logic slave_enable_pin_in = slave_enable_pin_oe_out ? slave_enable_pin_out : peer_sel_n;
  serial_spi_uart_unit u_dut (.*);
  spi_peer_model u_peer (.mosi_line(mosi_in), .miso_line(miso_in), .peer_sclk, .peer_mosi, .peer_sel_n,
    .peer_miso);
  always #10 clk_in = !clk_in;
  // ==========
  // Tasks
  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task chk(input logic ok, input string msg);
    compares++;
    if (!ok)
    begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task complete_run;
    $display("Checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  // New mode only under software reset hold
  task cfg(input logic [5:0] c);
    software_reset_hold_in = 1'b1;
    {master_mode_in, uart_mode_in, four_pin_mode_in, enable_pin_direction_in, capture_phase_select_in,
      clock_idle_polarity_in} = c;
    u_peer.idle(c[0]);
    tick(2);
    software_reset_hold_in = 1'b0;
    tick(5);
  endtask : cfg
  task wr(input logic [7:0] b);
    tx_data_in = b;
    tx_write_in = 1'b1;
    tick(1);
    tx_write_in = 1'b0;
  endtask : wr
  task pulse_read;
    rx_read_in = 1'b1;
    tick(1);
    rx_read_in = 1'b0;
  endtask : pulse_read
  // Bounded wait for busy to drop
  task wait_idle;
    int n;
    n = 0;
    tick(3);
    while (transfer_active_flag_out === 1'b1 && n < 500)
    begin
      tick(1);
      n++;
    end
    chk(n < 500, "transfer never finished");
  endtask : wait_idle
  // Hang guard
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    row_s r;
    logic [7:0] got;
    logic [9:0] frame;
    {resetn_in, software_reset_hold_in, master_mode_in, uart_mode_in, four_pin_mode_in, enable_pin_direction_in,
      capture_phase_select_in, clock_idle_polarity_in, tx_write_in, rx_read_in, tx_complete_clear_in} = '0;
    bit_divider_in = 16'h0004;
    tx_data_in = 8'h00;
    tick(12);
    chk(tx_buffer_empty_flag_out === 1'b1 && rx_char_ready_flag_out === 1'b0 && uart_txd_out === 1'b1, "reset");
    resetn_in = 1'b1;
    foreach (ROWS[k])
    begin
      r = ROWS[k];
      cfg({r.m, 3'b000, r.ph, r.pl});
      wr(r.tx);
      if (r.m)
        wait_idle();
      else
      begin
        u_peer.xfer(r.ph, r.pl, r.px, got);
        tick(6);
        chk(got === r.tx, "slave output char");
      end
      chk(rx_holding_buffer_out === (r.m ? r.tx : r.px), "received char");
      chk(rx_char_ready_flag_out === 1'b1 && tx_buffer_empty_flag_out === 1'b1, "flags after char");
      pulse_read();
      chk(rx_char_ready_flag_out === 1'b0, "ready not cleared");
    end
    // Lost receive: pulse the reset, master resends; four-pin slave selected by the enable pin
    cfg(6'b001010);
    wr(8'ha5);
    u_peer.xfer(1'b1, 1'b0, 8'h3c, got);
    tick(6);
    chk(got === 8'ha5, "resent char wrong");
    chk(rx_holding_buffer_out === 8'h3c && rx_char_ready_flag_out === 1'b1, "resend not received");
    // Enable input low blocks the master; abort mid-char, then rewrite
    u_peer.peer_sel_n = 1'b0;
    cfg(6'b101000);
    wr(8'h69);
    tick(30);
    chk(transfer_active_flag_out === 1'b0, "ran while blocked");
    u_peer.peer_sel_n = 1'b1;
    tick(4);
    wait_idle();
    pulse_read();
    wr(8'h69);
    tick(20);
    u_peer.peer_sel_n = 1'b0;
    wait_idle();
    chk(rx_char_ready_flag_out === 1'b0, "aborted char flagged");
    u_peer.peer_sel_n = 1'b1;
    tick(4);
    wr(8'h69);
    wait_idle();
    chk(rx_holding_buffer_out === 8'h69 && rx_char_ready_flag_out === 1'b1, "rewrite lost");
    // Enable pin as output
    cfg(6'b101100);
    wr(8'h96);
    tick(20);
    chk(slave_enable_pin_oe_out === 1'b1 && slave_enable_pin_out === 1'b0, "enable not driven");
    wait_idle();
    chk(slave_enable_pin_out === 1'b1, "enable left active");
    // UART: second char queued, complete flag still after the first
    cfg(6'b010000);
    frame = {1'b1, 8'h4b, 1'b0};
    wr(8'h4b);
    tick(2);
    wr(8'hd2);
    tick(1);
    for (int i = 0; i < 10; i++)
    begin
      chk(uart_txd_out === frame[i], "uart bit");
      tick(5);
    end
    chk(tx_complete_flag_out === 1'b1, "no complete, buffer full");
    tx_complete_clear_in = 1'b1;
    tick(1);
    tx_complete_clear_in = 1'b0;
    chk(tx_complete_flag_out === 1'b0, "complete not cleared");
    tick(60);
    chk(tx_complete_flag_out === 1'b1, "no complete, second char");
    complete_run();
  end
endmodule : serial_spi_uart_unit_test
`default_nettype wire
